// ===== core/adc_conversion_sequencer.sv
// How it works
// - Sample phase lasts 64, 128 or 4096 cycles
// - Compare phase lasts 44, 99 or 176 cycles
// - Conversion time is sample plus compare exactly
// - Sample-and-hold, then MSB-first successive approximation
// - Software picks 8-bit or 10-bit search
// - Exactly one of eight channels routed while busy, none while idle
// - Completion interrupt request, software enable
// - Start by software, timer, or external falling edge
// - Completion request can go to transfer service
// - Single-shot sweeps start to end, stops
// - Continuous sweep restarts at start channel
// - Incremental converts one channel per trigger
// - Incremental pointer wraps end back to start
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

module adc_conversion_sequencer #(
   parameter int SAMP_CYC0 = `ADC_SAMP_CYC_0,
   parameter int SAMP_CYC1 = `ADC_SAMP_CYC_1,
   parameter int SAMP_CYC2 = `ADC_SAMP_CYC_2,
   parameter int CMP_CYC0 = `ADC_CMP_CYC_0,
   parameter int CMP_CYC1 = `ADC_CMP_CYC_1,
   parameter int CMP_CYC2 = `ADC_CMP_CYC_2,
   parameter int STEP_CYC = `ADC_STEP_CYC
)(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_trig,
   input wire logic ext_trig_pin,
   input wire logic comp_pin,
   input wire logic xfer_ack,
   output adc_seq_pkg::ana_ctl_t ana,
   output logic irq_req,
   output logic xfer_req,
   output logic busy
);

   localparam int CW = 13;

   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   if (STEP_CYC < 3 || STEP_CYC > 15) begin : g_bad_step
      $error("STEP_CYC must lie in 3..15");
   end
   if (STEP_CYC * 10 >= CMP_CYC0 || STEP_CYC * 10 >= CMP_CYC1 || STEP_CYC * 10 >= CMP_CYC2)
   begin : g_bad_cmp
      $error("Compare phase too short for a 10-bit search");
   end
   if (SAMP_CYC0 < 1 || SAMP_CYC1 < 1 || SAMP_CYC2 < 1 || SAMP_CYC2 >= (1 << CW))
   begin : g_bad_samp
      $error("Sample counts must lie in 1..8191");
   end

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic [CW-1:0] phase_len(input logic [1:0] sel, input int a,
                                               input int b, input int c);
      case (sel)
         2'h1: phase_len = CW'(b - 1);
         2'h2: phase_len = CW'(c - 1);
         default: phase_len = CW'(a - 1);
      endcase
   endfunction

   function automatic logic [2:0] next_ch(input logic [2:0] ch, input logic [2:0] last,
                                          input logic [2:0] first);
      next_ch = (ch == last) ? first : ch + 3'h1;
   endfunction

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   adc_seq_pkg::ctrl_t ctrl_ff;
   logic [7:0] chan_ff;
   adc_seq_pkg::result_t result_ff;
   adc_seq_pkg::state_t state_ff;
   adc_seq_pkg::state_t nxt_state;
   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;
   logic [2:0] ch_ff;
   logic [2:0] nxt_ch;
   logic [2:0] ptr_ff;
   logic [2:0] nxt_ptr;
   logic commit;
   logic done_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic irq_ff;
   logic xfer_ff;
   logic busy_ff;
   logic [7:0] onehot_ff;
   logic hold_ff;
   logic ext_s1_ff;
   logic ext_s2_ff;
   logic ext_s3_ff;
   logic comp_s1_ff;
   logic comp_s2_ff;
   logic [9:0] trial;
   logic [9:0] sar_result;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire setup = psel && !penable;
   wire wr = psel && penable && pready_ff && pwrite;
   wire mapped = hit(paddr, `ADC_OFS_CTRL) || hit(paddr, `ADC_OFS_CHAN) ||
                 hit(paddr, `ADC_OFS_CMD) || hit(paddr, `ADC_OFS_STAT) ||
                 hit(paddr, `ADC_OFS_RESULT);
   wire wr_ctrl = wr && hit(paddr, `ADC_OFS_CTRL);
   wire wr_chan = wr && hit(paddr, `ADC_OFS_CHAN);
   wire wr_cmd = wr && hit(paddr, `ADC_OFS_CMD);
   wire wr_stat = wr && hit(paddr, `ADC_OFS_STAT);

   wire sw_start = wr_cmd && pwdata[`ADC_CMD_START_BIT];
   wire abort = wr_cmd && pwdata[`ADC_CMD_ABORT_BIT];
   wire done_clr = (wr_stat && pwdata[`ADC_STAT_DONE_BIT]) || xfer_ack;

   wire [2:0] start_ch = chan_ff[`ADC_CHAN_START_LSB +: 3];
   wire [2:0] end_ch = chan_ff[`ADC_CHAN_END_LSB +: 3];
   wire [31:0] stat_word = {24'h0, 1'b0, ch_ff, 2'h0, done_ff, busy_ff};
   wire [31:0] result_word = {13'h0, result_ff.ch, 6'h0, result_ff.data};

   wire [31:0] rd_mux = hit(paddr, `ADC_OFS_CTRL) ? ctrl_ff :
                        hit(paddr, `ADC_OFS_CHAN) ? {24'h0, chan_ff} :
                        hit(paddr, `ADC_OFS_STAT) ? stat_word :
                        hit(paddr, `ADC_OFS_RESULT) ? result_word : 32'h0;

   // ----------------------------------------
   // Trigger selection
   // ----------------------------------------
   // Only the third stage and the second meet the edge detector
   wire ext_fall = ext_s3_ff && !ext_s2_ff;
   wire trig_hit = (ctrl_ff.trig == adc_seq_pkg::TRIG_SW) ? sw_start :
                   (ctrl_ff.trig == adc_seq_pkg::TRIG_TIMER) ? timer_trig :
                   (ctrl_ff.trig == adc_seq_pkg::TRIG_EXT) ? ext_fall : 1'b0;
   // Triggers arriving while busy are dropped, not queued
   wire go = (state_ff == adc_seq_pkg::ST_IDLE) && trig_hit;
   wire is_incr = (ctrl_ff.mode == adc_seq_pkg::MODE_INCR);
   wire is_cont = (ctrl_ff.mode == adc_seq_pkg::MODE_CONT);

   wire [CW-1:0] samp_last = phase_len(ctrl_ff.samp_sel, SAMP_CYC0, SAMP_CYC1,
                                       SAMP_CYC2);
   wire [CW-1:0] cmp_last = phase_len(ctrl_ff.cmp_sel, CMP_CYC0, CMP_CYC1,
                                      CMP_CYC2);
   wire samp_end = (state_ff == adc_seq_pkg::ST_SAMPLE) && (cnt_ff == samp_last);
   wire cmp_end = (state_ff == adc_seq_pkg::ST_COMPARE) && (cnt_ff == cmp_last);

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff + CW'(1);
      nxt_ch = ch_ff;
      nxt_ptr = ptr_ff;
      commit = 1'b0;
      case (state_ff)
         adc_seq_pkg::ST_IDLE: begin
            nxt_cnt = '0;
            if (go) begin
               nxt_state = adc_seq_pkg::ST_SAMPLE;
               nxt_ch = is_incr ? ptr_ff : start_ch;
            end
         end
         adc_seq_pkg::ST_SAMPLE: begin
            if (samp_end) begin
               nxt_state = adc_seq_pkg::ST_COMPARE;
               nxt_cnt = '0;
            end
         end
         adc_seq_pkg::ST_COMPARE: begin
            if (cmp_end) begin
               commit = 1'b1;
               nxt_cnt = '0;
               if (is_incr) begin
                  nxt_state = adc_seq_pkg::ST_IDLE;
                  nxt_ptr = next_ch(ch_ff, end_ch, start_ch);
               end else if (ch_ff == end_ch) begin
                  nxt_state = is_cont ? adc_seq_pkg::ST_SAMPLE :
                              adc_seq_pkg::ST_IDLE;
                  nxt_ch = start_ch;
               end else begin
                  nxt_state = adc_seq_pkg::ST_SAMPLE;
                  nxt_ch = next_ch(ch_ff, end_ch, start_ch);
               end
            end
         end
         default: begin
            nxt_state = adc_seq_pkg::ST_IDLE;
            nxt_cnt = '0;
         end
      endcase
      if (abort) begin
         nxt_state = adc_seq_pkg::ST_IDLE;
         nxt_cnt = '0;
      end
      // Rewriting the channel range restarts the incremental pointer
      if (wr_chan) begin
         nxt_ptr = pwdata[`ADC_CHAN_START_LSB +: 3];
      end
   end

   wire cmp_start = samp_end && !abort;
   wire running = (nxt_state != adc_seq_pkg::ST_IDLE);
   wire nxt_done = commit || (done_ff && !done_clr);
   wire req_on = nxt_done && ctrl_ff.irq_en;

   sar_step_engine #(
      .STEP_CYC(STEP_CYC)
   ) u_sar (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .start(cmp_start),
      .res10(ctrl_ff.res10),
      .comp_hi(comp_s2_ff),
      .trial(trial),
      .result(sar_result)
   );

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ext_s1_ff <= 1'b1;
         ext_s2_ff <= 1'b1;
         ext_s3_ff <= 1'b1;
         comp_s1_ff <= 1'b0;
         comp_s2_ff <= 1'b0;
      end else begin
         ext_s1_ff <= ext_trig_pin;
         ext_s2_ff <= ext_s1_ff;
         ext_s3_ff <= ext_s2_ff;
         comp_s1_ff <= comp_pin;
         comp_s2_ff <= comp_s1_ff;
      end
   end

   // ----------------------------------------
   // State and status
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_ff <= adc_seq_pkg::ST_IDLE;
         cnt_ff <= '0;
         ch_ff <= 3'h0;
         ptr_ff <= 3'h0;
         done_ff <= 1'b0;
         busy_ff <= 1'b0;
         onehot_ff <= 8'h00;
         hold_ff <= 1'b0;
         irq_ff <= 1'b0;
         xfer_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         ch_ff <= nxt_ch;
         ptr_ff <= nxt_ptr;
         done_ff <= nxt_done;
         busy_ff <= running;
         onehot_ff <= running ? (8'h01 << nxt_ch) : 8'h00;
         hold_ff <= (nxt_state == adc_seq_pkg::ST_SAMPLE);
         irq_ff <= req_on && !ctrl_ff.xfer_en;
         xfer_ff <= req_on && ctrl_ff.xfer_en;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         result_ff <= '0;
      end else if (commit) begin
         result_ff <= '{ch: ch_ff, data: sar_result};
      end
   end

   // ----------------------------------------
   // Register file and bus answer
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_ff <= `ADC_CTRL_RST;
         chan_ff <= `ADC_CHAN_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= {21'h0, pwdata[10:0]};
         end
         if (wr_chan) begin
            chan_ff <= pwdata[7:0] & 8'h77;
         end
      end
   end

   // Zero wait states: answer lands in the first access cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         prdata_ff <= 32'h0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         prdata_ff <= setup ? rd_mux : 32'h0;
         pready_ff <= setup;
         pslverr_ff <= setup && !mapped;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq_req = irq_ff;
   assign xfer_req = xfer_ff;
   assign busy = busy_ff;
   assign ana = '{ch_onehot: onehot_ff, sample_hold: hold_ff, trial: trial};

endmodule // adc_conversion_sequencer

// ===== core/adc_seq_consts.svh
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ADC_OFS_CTRL 8'h00
`define ADC_OFS_CHAN 8'h04
`define ADC_OFS_CMD 8'h08
`define ADC_OFS_STAT 8'h0c
`define ADC_OFS_RESULT 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADC_CHAN_START_LSB 0
`define ADC_CHAN_END_LSB 4
`define ADC_CMD_START_BIT 0
`define ADC_CMD_ABORT_BIT 1
`define ADC_STAT_BUSY_BIT 0
`define ADC_STAT_DONE_BIT 1
`define ADC_STAT_CH_LSB 4
`define ADC_RESULT_CH_LSB 16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADC_CTRL_RST 32'h0000_0000
`define ADC_CHAN_RST 8'h70

// ----------------------------------------
// Timing counts in machine cycles
// ----------------------------------------
`define ADC_SAMP_CYC_0 64
`define ADC_SAMP_CYC_1 128
`define ADC_SAMP_CYC_2 4096
`define ADC_CMP_CYC_0 44
`define ADC_CMP_CYC_1 99
`define ADC_CMP_CYC_2 176
`define ADC_STEP_CYC 4

`endif

// ===== core/adc_seq_pkg.sv
package adc_seq_pkg;

   // ----------------------------------------
   // Modes, trigger sources, states
   // ----------------------------------------
   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00,
      MODE_CONT = 2'b01,
      MODE_INCR = 2'b10
   } mode_t;

   typedef enum logic [1:0] {
      TRIG_SW = 2'b00,
      TRIG_TIMER = 2'b01,
      TRIG_EXT = 2'b10,
      TRIG_OFF = 2'b11
   } trig_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_COMPARE = 2'b10
   } state_t;

   // ----------------------------------------
   // Control register layout
   // ----------------------------------------
   typedef struct packed {
      logic [20:0] rsvd;
      logic xfer_en;
      logic irq_en;
      logic [1:0] cmp_sel;
      logic [1:0] samp_sel;
      logic res10;
      logic [1:0] mode;
      logic [1:0] trig;
   } ctrl_t;

   // Drive toward the analog front end
   typedef struct packed {
      logic [7:0] ch_onehot;
      logic sample_hold;
      logic [9:0] trial;
   } ana_ctl_t;

   // Stored conversion result
   typedef struct packed {
      logic [2:0] ch;
      logic [9:0] data;
   } result_t;

endpackage

// ===== core/sar_step_engine.sv
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

module sar_step_engine #(
   parameter int STEP_CYC = `ADC_STEP_CYC
)(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic res10,
   input wire logic comp_hi,
   output logic [9:0] trial,
   output logic [9:0] result
);

   localparam logic [3:0] STEP_LAST = 4'(STEP_CYC - 1);

   if (STEP_CYC < 1 || STEP_CYC > 16) begin : g_bad_step
      $error("STEP_CYC must lie in 1..16");
   end

   logic [9:0] code_ff;
   logic [3:0] idx_ff;
   logic [3:0] step_ff;
   logic active_ff;
   logic [9:0] nxt_code;
   logic [3:0] nxt_idx;
   logic [3:0] nxt_step;
   logic nxt_active;

   wire [3:0] lsb_idx = res10 ? 4'h0 : 4'h2;
   wire decide = active_ff && (step_ff == STEP_LAST);
   wire [9:0] cur_bit = 10'h001 << idx_ff;
   wire [9:0] kept = comp_hi ? code_ff : (code_ff & ~cur_bit);
   wire last_bit = (idx_ff == lsb_idx);

   // ----------------------------------------
   // One bit per step, MSB first
   // ----------------------------------------
   always_comb begin
      nxt_code = code_ff;
      nxt_idx = idx_ff;
      nxt_step = step_ff;
      nxt_active = active_ff;
      if (start) begin
         nxt_code = 10'h200;
         nxt_idx = 4'h9;
         nxt_step = 4'h0;
         nxt_active = 1'b1;
      end else if (decide) begin
         nxt_step = 4'h0;
         nxt_code = kept;
         if (last_bit) begin
            nxt_active = 1'b0;
         end else begin
            nxt_idx = idx_ff - 4'h1;
            nxt_code = kept | (cur_bit >> 1);
         end
      end else if (active_ff) begin
         nxt_step = step_ff + 4'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         code_ff <= 10'h000;
         idx_ff <= 4'h0;
         step_ff <= 4'h0;
         active_ff <= 1'b0;
      end else begin
         code_ff <= nxt_code;
         idx_ff <= nxt_idx;
         step_ff <= nxt_step;
         active_ff <= nxt_active;
      end
   end

   assign trial = code_ff;
   // 8-bit results sit in the low bits
   assign result = res10 ? code_ff : {2'h0, code_ff[9:2]};

endmodule // sar_step_engine

// ===== verification/adc_seq_props.sv
`timescale 1ns/1ps
module adc_seq_props #(
   parameter int SAMP_CYC0 = 64,
   parameter int SAMP_CYC1 = 128,
   parameter int SAMP_CYC2 = 4096,
   parameter int CMP_CYC0 = 44,
   parameter int CMP_CYC1 = 99,
   parameter int CMP_CYC2 = 176
)(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timer_trig,
   input wire logic ext_trig_pin,
   input wire adc_seq_pkg::ana_ctl_t ana,
   input wire logic irq_req,
   input wire logic xfer_req,
   input wire logic busy
);
   // ----------------------------------------
   // Shadow of control and phase counters
   // ----------------------------------------
   adc_seq_pkg::ctrl_t ctrl_sh_ff;
   logic abort_ff;
   int samp_cnt_ff;
   int cmp_cnt_ff;
   int samp_len;
   int cmp_len;
   wire wr_done = psel && penable && pready && pwrite && !pslverr;
   assign samp_len = ctrl_sh_ff.samp_sel == 2'h1 ? SAMP_CYC1 :
                     ctrl_sh_ff.samp_sel == 2'h2 ? SAMP_CYC2 : SAMP_CYC0;
   assign cmp_len = ctrl_sh_ff.cmp_sel == 2'h1 ? CMP_CYC1 :
                    ctrl_sh_ff.cmp_sel == 2'h2 ? CMP_CYC2 : CMP_CYC0;
   // An abort cuts a phase short, so length checks skip that cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_sh_ff <= '0;
         abort_ff <= 1'h0;
         samp_cnt_ff <= 0;
         cmp_cnt_ff <= 0;
      end else begin
         if (wr_done && paddr == 8'h00)
            ctrl_sh_ff <= pwdata;
         abort_ff <= wr_done && paddr == 8'h08 && pwdata[1];
         samp_cnt_ff <= ana.sample_hold ? samp_cnt_ff + 1 : 0;
         cmp_cnt_ff <= (busy && !ana.sample_hold) ? cmp_cnt_ff + 1 : 0;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_samp_len: assert property ($fell(ana.sample_hold) && !abort_ff |-> samp_cnt_ff == samp_len)
      else $error("sample phase length wrong");
   a_cmp_len: assert property (($rose(ana.sample_hold) || $fell(busy)) && cmp_cnt_ff != 0
      && !abort_ff |-> cmp_cnt_ff == cmp_len) else $error("compare phase length wrong");
   a_one_channel: assert property (busy |-> $onehot(ana.ch_onehot))
      else $error("channel select not one-hot");
   a_idle_quiet: assert property (!busy |-> ana.ch_onehot == 8'h00 && !ana.sample_hold)
      else $error("channel or hold active while idle");
   a_trial_msb: assert property ($fell(ana.sample_hold) && busy |-> ana.trial == 10'h200)
      else $error("search does not begin at top bit");
   a_req_excl: assert property (!(irq_req && xfer_req))
      else $error("both completion requests high");
   a_pready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("ready not a single access pulse");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_timer_start: assert property (ctrl_sh_ff.trig == 2'h1 && !busy && timer_trig
      |=> busy && ana.sample_hold) else $error("timer trigger not taken");
   a_ext_start: assert property (ctrl_sh_ff.trig == 2'h2 && !busy && $fell(ext_trig_pin)
      |-> ##[1:6] busy) else $error("pin falling edge not taken");
   a_done_req: assert property ($fell(busy) && !abort_ff && ctrl_sh_ff.irq_en
      |=> (ctrl_sh_ff.xfer_en ? xfer_req : irq_req)) else $error("completion request missing");
   a_req_gated: assert property (!ctrl_sh_ff.irq_en |=> !irq_req && !xfer_req)
      else $error("completion request while disabled");
   a_trial_8bit: assert property (busy && !ana.sample_hold && !ctrl_sh_ff.res10
      |-> ana.trial[1:0] == 2'h0) else $error("8-bit search touched low bits");
   c_res10: cover property ($fell(busy) && ctrl_sh_ff.res10);
   c_xfer: cover property ($rose(xfer_req));
   c_err: cover property (pslverr);
endmodule // adc_seq_props

// ===== verification/analog_front_model.sv
`timescale 1ns/1ps
module analog_front_model (
   input wire logic ref_clk,
   input wire logic [9:0] base,
   input wire adc_seq_pkg::ana_ctl_t ana,
   output logic comp_pin
);
   // ----------------------------------------
   // Hold capacitor and comparator
   // ----------------------------------------
   logic [9:0] held_ff = 10'h000;
   logic tog_ff = 1'h0;
   always_ff @(posedge ref_clk) begin
      tog_ff <= !tog_ff;
      for (int i = 0; i < 8; i++)
         if (ana.sample_hold && ana.ch_onehot[i])
            held_ff <= base + 10'(i) * 10'h07b;
   end
   // Deselected comparator output wanders rather than holding a stale level
   assign comp_pin = (ana.ch_onehot == 8'h00) ? tog_ff : (held_ff >= ana.trial);
endmodule // analog_front_model

// ===== verification/adc_conversion_sequencer_bench.sv
`timescale 1ns/1ps
module adc_conversion_sequencer_bench;
   // ----------------------------------------
   // Signals and bookkeeping
   // ----------------------------------------
   localparam logic [32:0] ALL = 33'h1_ffff_ffff;
   logic ref_clk, rst_n, psel, penable, pwrite, timer_trig, ext_trig_pin, xfer_ack;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rng;
   logic pready, pslverr, comp_pin, irq_req, xfer_req, busy;
   logic sh_q = 1'h0;
   logic [9:0] base;
   adc_seq_pkg::ana_ctl_t ana;
   int n_mismatch = 0;
   int n_tests = 0;
   int n_conv = 0;
   logic [32:0] rd_exp_q[$];
   logic [32:0] rd_msk_q[$];
   logic [7:0] ch_q[$];

   adc_conversion_sequencer #(.SAMP_CYC2(16)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_trig(timer_trig),
      .ext_trig_pin(ext_trig_pin), .comp_pin(comp_pin), .xfer_ack(xfer_ack), .ana(ana),
      .irq_req(irq_req), .xfer_req(xfer_req), .busy(busy));
   analog_front_model front (.ref_clk(ref_clk), .base(base), .ana(ana), .comp_pin(comp_pin));

   initial begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic [31:0] ctrl(input int t, m, r, s, c, ie, xe);
      return {21'h0, 1'(xe), 1'(ie), 2'(c), 2'(s), 1'(r), 2'(m), 2'(t)};
   endfunction
   task wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      do
         @(posedge ref_clk);
      while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
      rd_exp_q.push_back(e);
      rd_msk_q.push_back(m);
      apb(1'h0, a, 32'h0);
   endtask
   task rd_res(input int ch, input logic r10);
      logic [9:0] v;
      v = base + 10'(ch) * 10'h07b;
      rd(8'h10, {1'h0, 13'h0, 3'(ch), 6'h0, r10 ? v : {2'h0, v[9:2]}}, ALL);
   endtask
   task wait_idle;
      repeat (8) @(posedge ref_clk);
      while (busy !== 1'h0)
         @(posedge ref_clk);
   endtask
   task chk_rd(input logic [32:0] e, input logic [32:0] got, input logic [32:0] m);
      n_tests++;
      if ((got & m) !== (e & m)) begin
         n_mismatch++;
         $display("[FAIL] read %h expected %h seen %h", paddr, e & m, got & m);
      end
   endtask
   task chk_ch(input logic [7:0] e, input logic [7:0] got);
      n_tests++;
      if (got !== e) begin
         n_mismatch++;
         $display("[FAIL] channel expected %h seen %h", e, got);
      end
   endtask
   // ----------------------------------------
   // Monitor: results meet their notes
   // ----------------------------------------
   always @(posedge ref_clk) begin
      if (psel && penable && pready === 1'h1 && !pwrite)
         chk_rd(rd_exp_q.pop_front(), {pslverr, prdata}, rd_msk_q.pop_front());
      if (ana.sample_hold === 1'h1 && sh_q === 1'h0) begin
         n_conv++;
         chk_ch(ch_q.size() > 0 ? ch_q.pop_front() : 8'h00, ana.ch_onehot);
      end
      sh_q <= ana.sample_hold;
   end
   initial begin
      repeat (30000) @(posedge ref_clk);
      n_mismatch++;
      $display("[FAIL] watchdog expected finish seen timeout");
      wrap_up;
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {psel, penable, pwrite, timer_trig, xfer_ack, rst_n} = 6'h0;
      {paddr, pwdata} = 40'h0;
      ext_trig_pin = 1'h1;
      base = 10'h0;
      rng = 32'h0001_7614;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'h1;
      rd(8'h00, 33'h0, ALL);
      rd(8'h04, 33'h70, ALL);
      apb(1'h1, 8'h14, 32'hffff_ffff);
      rd(8'h14, 33'h1_0000_0000, ALL);
      $display("test reset_map done");
      rng = xs(rng);
      base <= rng[9:0];
      apb(1'h1, 8'h00, ctrl(0, 0, 0, 1, 2, 1, 0));
      apb(1'h1, 8'h04, 32'h16);
      for (int i = 0; i < 4; i++) ch_q.push_back(8'h01 << ((6 + i) % 8));
      apb(1'h1, 8'h08, 32'h1);
      wait_idle;
      rd_res(1, 1'h0);
      rd(8'h0c, 33'h2, 33'h3);
      apb(1'h1, 8'h0c, 32'h2);
      rd(8'h0c, 33'h0, 33'h2);
      $display("test single_wrap done");
      for (int i = 0; i < 3; i++) begin
         rng = xs(rng);
         base <= rng[9:0];
         apb(1'h1, 8'h00, ctrl(0, 0, i % 2, i, i, 0, 0));
         apb(1'h1, 8'h04, 32'h55);
         ch_q.push_back(8'h20);
         apb(1'h1, 8'h08, 32'h1);
         wait_idle;
         rd_res(5, 1'(i % 2));
      end
      $display("test timing_sel done");
      apb(1'h1, 8'h00, ctrl(1, 2, 1, 0, 0, 1, 1));
      apb(1'h1, 8'h04, 32'h43);
      apb(1'h1, 8'h08, 32'h1);
      for (int i = 0; i < 3; i++) begin
         ch_q.push_back(8'h08 << (i % 2));
         timer_trig <= 1'h1;
         @(posedge ref_clk);
         timer_trig <= 1'h0;
         wait_idle;
         rd_res(3 + i % 2, 1'h1);
      end
      rd(8'h0c, 33'h2, 33'h3);
      xfer_ack <= 1'h1;
      @(posedge ref_clk);
      xfer_ack <= 1'h0;
      rd(8'h0c, 33'h0, 33'h2);
      $display("test incremental done");
      apb(1'h1, 8'h00, ctrl(2, 1, 0, 0, 0, 1, 0));
      apb(1'h1, 8'h04, 32'h32);
      for (int i = 0; i < 4; i++) ch_q.push_back(8'h04 << (i % 2));
      begin
         int k0;
         k0 = n_conv;
         ext_trig_pin <= 1'h0;
         while (n_conv < k0 + 4)
            @(posedge ref_clk);
      end
      ext_trig_pin <= 1'h1;
      apb(1'h1, 8'h08, 32'h2);
      repeat (4) @(posedge ref_clk);
      rd(8'h0c, 33'h0, 33'h1);
      $display("test continuous done");
      wrap_up;
   end
endmodule // adc_conversion_sequencer_bench

bind adc_conversion_sequencer adc_seq_props #(.SAMP_CYC0(SAMP_CYC0), .SAMP_CYC1(SAMP_CYC1),
   .SAMP_CYC2(SAMP_CYC2), .CMP_CYC0(CMP_CYC0), .CMP_CYC1(CMP_CYC1), .CMP_CYC2(CMP_CYC2))
   props (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .timer_trig(timer_trig), .ext_trig_pin(ext_trig_pin), .ana(ana), .irq_req(irq_req),
   .xfer_req(xfer_req), .busy(busy));
